// >>> tb/host_model.sv
module host_model
  import synth_path_pkg::*;
(
  input  wire logic                 i_clk,
  input  wire logic                 i_rd_valid,
  input  wire logic [7:0]           i_rdata,
  output synth_path_pkg::reg_req_t  o_req
);
  timeunit 1ns;
  timeprecision 1ps;
  initial o_req = '0;
  // one strobe cycle, then address and data scrambled
  task automatic write_reg(input logic [11:0] a, input logic [7:0] d);
    @(posedge i_clk) #1;
    o_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge i_clk) #1;
    o_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask : write_reg
  // read strobe, then bounded wait for the valid pulse
  task automatic read_reg(input logic [11:0] a, output logic [7:0] d);
    @(posedge i_clk) #1;
    o_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: o_req.wdata};
    @(posedge i_clk) #1;
    o_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~o_req.wdata};
    for (int n = 0; n < 3 && i_rd_valid !== 1'b1; n++) @(posedge i_clk) #1;
    d = (i_rd_valid === 1'b1) ? i_rdata : 8'hxx;
  endtask : read_reg
endmodule : host_model

// >>> tb/synth_path_asserts.sv
module synth_path_asserts
  import synth_path_pkg::*;
(
  input wire logic                       i_clk,
  input wire logic                       i_arst_n,
  input wire synth_path_pkg::reg_req_t   i_req,
  input wire logic [7:0]                 o_rdata,
  input wire logic                       o_rd_valid,
  input wire logic                       i_adc_enable,
  input wire logic                       i_cmp_tick,
  input wire logic [7:0]                 o_cal_adc_offset,
  input wire synth_path_pkg::path_ctrl_t o_ctrl,
  input wire logic                       o_lock_state
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  // write strobes per register, read strobe for status
  wire w_ofs = i_req.wr && i_req.addr == OFS_CAL_ADC_OFFSET;
  wire w_pmp = i_req.wr && i_req.addr == OFS_PUMP_TEST_MODE;
  wire w_adc = i_req.wr && i_req.addr == OFS_ADC_DIVIDER_LOCK_CTRL;
  wire w_pth = i_req.wr && i_req.addr == OFS_SIGNAL_PATH_CTRL;
  wire r_sts = i_req.rd && i_req.addr == OFS_LOCK_STATUS;
  // lone write, no rewrite in the next cycle
  sequence s_adc_wr;
    w_adc && !i_adc_enable ##1 !w_adc && !i_adc_enable;
  endsequence
  sequence s_pth_wr;
    w_pth ##1 !w_pth;
  endsequence
  chk_rd_valid_pulse: assert property (i_req.rd ##1 !i_req.rd |->
    o_rd_valid ##1 !o_rd_valid) else $error("read valid not one pulse");
  chk_rd_valid_cause: assert property (o_rd_valid |-> $past(i_req.rd))
    else $error("read valid without read");
  chk_offset_write: assert property (w_ofs ##1 !w_ofs |=>
    o_cal_adc_offset == $past(i_req.wdata, 2)) else $error("offset");
  chk_pump_decode: assert property (w_pmp ##1 !w_pmp |=>
    o_ctrl.pump_normal == ($past(i_req.wdata[3:2], 2) == PUMP_NORMAL) &&
    o_ctrl.pump_tristate == ($past(i_req.wdata[3:2], 2) == PUMP_TRISTATE))
    else $error("pump decode");
  chk_path_decode: assert property (s_pth_wr |=>
    o_ctrl.if_amp_off == $past(i_req.wdata[5:3], 2) &&
    o_ctrl.rf_bias_off == $past(i_req.wdata[7], 2) &&
    o_ctrl.mixer_bypass_select == !$past(i_req.wdata[1], 2) &&
    o_ctrl.if_switch_on == $past(i_req.wdata[0], 2)) else $error("path");
  chk_adc_divider: assert property (s_adc_wr |=>
    o_ctrl.feedback_divider_off == $past(i_req.wdata[1], 2) &&
    o_ctrl.adc_clk_run == !$past(i_req.wdata[2], 2)) else $error("adc");
  chk_clk_override: assert property (i_adc_enable [*2] |=>
    o_ctrl.adc_clk_run) else $error("adc enable override");
  chk_lock_rise: assert property ($rose(o_lock_state) |->
    $past(i_cmp_tick, 2)) else $error("lock without tick");
  chk_status_rsvd: assert property (r_sts |=>
    o_rdata[7:1] == 7'h00) else $error("status reserved bits");
endmodule : synth_path_asserts

bind synth_and_path_ctrl_regs synth_path_asserts u_chk (.i_clk, .i_arst_n,
  .i_req, .o_rdata, .o_rd_valid, .i_adc_enable, .i_cmp_tick,
  .o_cal_adc_offset, .o_ctrl, .o_lock_state);

// >>> tb/tb_top.sv
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
  fail_count++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import synth_path_pkg::*;
  logic       i_clk, i_arst_n, adc_en, vld, tick, ok, rd_valid, lock;
  logic [15:0] meas;
  logic [1:0] code;
  logic [7:0] rdata, ofs;
  reg_req_t   req;
  path_ctrl_t ctrl;
  int         fail_count = 0;
  int         n_compared = 0;
  host_model h (.i_clk(i_clk), .i_rd_valid(rd_valid), .i_rdata(rdata),
    .o_req(req));
  synth_and_path_ctrl_regs uut (.i_clk(i_clk), .i_arst_n(i_arst_n),
    .i_req(req), .o_rdata(rdata), .o_rd_valid(rd_valid),
    .i_adc_enable(adc_en), .i_cal_meas(meas), .i_cal_meas_valid(vld),
    .i_cmp_tick(tick), .i_phase_ok_pin(ok), .i_lock_cycle_count(code),
    .o_cal_adc_offset(ofs), .o_ctrl(ctrl), .o_lock_state(lock));
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  task automatic rc(input logic [11:0] a, input logic [7:0] e);
    logic [7:0] d;
    h.read_reg(a, d);
    `CHK("rdata", e, d)
  endtask : rc
  task automatic wt(input int n);
    repeat (n) @(posedge i_clk) #1;
  endtask : wt
  // clear lock, tick one short of target, then hit it
  task automatic lock_run(input logic s, input logic [1:0] c, input int t);
    h.write_reg(OFS_ADC_DIVIDER_LOCK_CTRL, {7'h00, s});
    code = c;
    ok = 1'b0;
    wt(6);
    tick = 1'b1;
    wt(1);
    tick = 1'b0;
    ok = 1'b1;
    wt(6);
    tick = 1'b1;
    wt(t - 1);
    tick = 1'b0;
    wt(5);
    `CHK("early", 1'b0, lock)
    tick = 1'b1;
    wt(1);
    tick = 1'b0;
    wt(5);
    `CHK("lock", 1'b1, lock)
  endtask : lock_run
  initial begin
    #200000;
    fail_count++;
    end_sim();
  end
  initial begin
    {i_arst_n, adc_en, vld, tick, ok, meas, code} = '0;
    repeat (8) @(posedge i_clk);
    #1 i_arst_n = 1'b1;
    wt(1);
    `CHK("tristate", 1'b1, ctrl.pump_tristate)
    `CHK("switch", 1'b1, ctrl.if_switch_on)
    `CHK("bypass", 1'b0, ctrl.mixer_bypass_select)
    `CHK("divoff", 1'b0, ctrl.feedback_divider_off)
    rc(OFS_CAL_ADC_OFFSET, 8'h00);
    rc(OFS_PUMP_TEST_MODE, 8'h00);
    rc(OFS_OSC_CAL_RESULT_LOW, 8'h00);
    rc(OFS_OSC_CAL_RESULT_HIGH, 8'h00);
    rc(OFS_ADC_DIVIDER_LOCK_CTRL, 8'h00);
    rc(OFS_LOCK_STATUS, 8'h00);
    rc(OFS_SIGNAL_PATH_CTRL, 8'h03);
    rc(12'h001, RD_UNMAPPED);
    $display("test reset done");
    h.write_reg(OFS_CAL_ADC_OFFSET, 8'h5a);
    h.write_reg(OFS_PUMP_TEST_MODE, 8'h0c);
    h.write_reg(OFS_ADC_DIVIDER_LOCK_CTRL, 8'h06);
    h.write_reg(OFS_SIGNAL_PATH_CTRL, 8'h3a);
    wt(2);
    `CHK("normal", 1'b1, ctrl.pump_normal)
    `CHK("divoff", 1'b1, ctrl.feedback_divider_off)
    `CHK("adcclk", 1'b0, ctrl.adc_clk_run)
    `CHK("ifamp", 3'h7, ctrl.if_amp_off)
    `CHK("switch", 1'b0, ctrl.if_switch_on)
    adc_en = 1'b1;
    wt(3);
    `CHK("adcclk", 1'b1, ctrl.adc_clk_run)
    h.write_reg(OFS_SIGNAL_PATH_CTRL, 8'h81);
    wt(2);
    `CHK("bias", 1'b1, ctrl.rf_bias_off)
    `CHK("bypass", 1'b1, ctrl.mixer_bypass_select)
    `CHK("ifamp", 3'h0, ctrl.if_amp_off)
    `CHK("offset", 8'h5a, ofs)
    rc(OFS_PUMP_TEST_MODE, 8'h0c);
    $display("test writes done");
    meas = 16'h12c0;
    vld = 1'b1;
    wt(1);
    vld = 1'b0;
    rc(OFS_OSC_CAL_RESULT_LOW, 8'h1a);
    foreach (meas[i]) if (i < 3)
      h.write_reg(OFS_OSC_CAL_RESULT_LOW + 12'(i == 2 ? 14 : i), 8'hff);
    rc(OFS_OSC_CAL_RESULT_LOW, 8'h1a);
    rc(OFS_OSC_CAL_RESULT_HIGH, 8'h13);
    rc(OFS_LOCK_STATUS, 8'h00);
    $display("test calibration done");
    lock_run(1'b1, 2'h0, 32);
    rc(OFS_LOCK_STATUS, 8'h01);
    lock_run(1'b1, 2'h1, 64);
    lock_run(1'b1, 2'h2, 128);
    lock_run(1'b1, 2'h3, 256);
    lock_run(1'b0, 2'h0, 1024);
    $display("test lock done");
    end_sim();
  end
endmodule : tb_top

// >>> verilog/lock_detector.sv
module lock_detector
  import synth_path_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_arst_n,
  input  wire logic       i_cmp_tick,
  input  wire logic       i_phase_ok,
  input  wire logic [1:0] i_lock_cycle_count,
  input  wire logic       i_lock_count_scale,
  output logic            o_lock_state
);

  typedef enum logic [0:0] {
    HUNTING = 1'b0,
    LOCKED  = 1'b1
  } lock_fsm_t;

  lock_fsm_t   state;
  lock_fsm_t   next_state;
  logic [13:0] count;
  logic [13:0] next_count;
  wire  [13:0] target;

  // lock count: 1024 << sel, divided by 32 when scaled
  function automatic logic [13:0] lock_target(input logic [1:0] sel,
                                              input logic       scale);
    logic [13:0] full;
    full = LOCK_BASE_COUNT << sel;
    lock_target = scale ? (full >> LOCK_SCALE_SHIFT) : full;
  endfunction : lock_target

  assign target = lock_target(i_lock_cycle_count, i_lock_count_scale);

  // count consecutive good comparisons, any bad one restarts
  always_comb begin
    next_state = state;
    next_count = count;
    if (i_cmp_tick) begin
      if (!i_phase_ok) begin
        next_state = HUNTING;
        next_count = 14'h0000;
      end else begin
        case (state)
          HUNTING: begin
            next_count = count + 14'h0001;
            if (next_count >= target) begin
              next_state = LOCKED;
            end
          end
          LOCKED: begin
            next_count = count;
          end
          default: begin
            next_state = HUNTING;
            next_count = 14'h0000;
          end
        endcase
      end
    end
  end

  // state registers
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state        <= HUNTING;
      count        <= 14'h0000;
      o_lock_state <= 1'b0;
    end else begin
      state        <= next_state;
      count        <= next_count;
      o_lock_state <= (next_state == LOCKED);
    end
  end

endmodule : lock_detector

// >>> verilog/synth_and_path_ctrl_regs.sv
// Operation
// - 8-bit writable ADC offset, reset zero, added to calibration measurement.
// - pump test field bits 3:2: 00 tristates pump, 11 normal.
// - 16-bit read-only calibration result: low byte then high byte address.
// - ADC clock off when disable bit set, unless ADC enable asserted.
// - divider off bit powers down feedback divider; reset keeps it running.
// - lock after 1024..8192 comparisons, or that divided by 32.
// - status bit 0 shows lock; bits 7:1 read zero; reset zero.
// - path register resets 0x03; bit 7 bias off, bit 1 mixer.
// - IF amplifier field bits 5:3: 000 all up, 111 all down.
// - path bit 0 turns IF input switch on or off.
module synth_and_path_ctrl_regs
  import synth_path_pkg::*;
(
  input  wire logic                     i_clk,
  input  wire logic                     i_arst_n,
  input  wire synth_path_pkg::reg_req_t i_req,
  output logic [7:0]                    o_rdata,
  output logic                          o_rd_valid,
  input  wire logic                     i_adc_enable,
  input  wire logic [15:0]              i_cal_meas,
  input  wire logic                     i_cal_meas_valid,
  input  wire logic                     i_cmp_tick,
  input  wire logic                     i_phase_ok_pin,
  input  wire logic [1:0]               i_lock_cycle_count,
  output logic [7:0]                    o_cal_adc_offset,
  output synth_path_pkg::path_ctrl_t    o_ctrl,
  output logic                          o_lock_state
);

  import synth_path_pkg::*;

  // ****************************************************************
  // storage
  // ****************************************************************
  logic [7:0]  cal_adc_offset;
  logic [7:0]  pump_test_mode;
  logic [7:0]  adc_divider_lock_ctrl;
  logic [7:0]  signal_path_ctrl;
  logic [15:0] osc_cal_result;
  logic [2:0]  phase_sync;
  logic        phase_ok;
  logic        lock_state;

  // ****************************************************************
  // address decode
  // ****************************************************************
  // one register offset against the request address, exact match
  function automatic logic addr_hit(input logic [11:0] addr,
                                    input logic [11:0] ofs);
    addr_hit = (addr == ofs);
  endfunction : addr_hit

  wire hit_offset  = addr_hit(i_req.addr, OFS_CAL_ADC_OFFSET);
  wire hit_pump    = addr_hit(i_req.addr, OFS_PUMP_TEST_MODE);
  wire hit_res_lo  = addr_hit(i_req.addr, OFS_OSC_CAL_RESULT_LOW);
  wire hit_res_hi  = addr_hit(i_req.addr, OFS_OSC_CAL_RESULT_HIGH);
  wire hit_lockctl = addr_hit(i_req.addr, OFS_ADC_DIVIDER_LOCK_CTRL);
  wire hit_status  = addr_hit(i_req.addr, OFS_LOCK_STATUS);
  wire hit_path    = addr_hit(i_req.addr, OFS_SIGNAL_PATH_CTRL);

  // write strobes, read-only offsets get none
  wire wr_offset  = i_req.wr & hit_offset;
  wire wr_pump    = i_req.wr & hit_pump;
  wire wr_lockctl = i_req.wr & hit_lockctl;
  wire wr_path    = i_req.wr & hit_path;

  // read mux, status reserved bits read zero
  wire [7:0] status_word = {7'h00, lock_state};
  wire [7:0] rd_mux =
    hit_offset  ? cal_adc_offset :
    hit_pump    ? pump_test_mode :
    hit_res_lo  ? osc_cal_result[7:0] :
    hit_res_hi  ? osc_cal_result[15:8] :
    hit_lockctl ? adc_divider_lock_ctrl :
    hit_status  ? status_word :
    hit_path    ? signal_path_ctrl : RD_UNMAPPED;

  // offset-corrected calibration measurement
  wire [15:0] cal_corrected = i_cal_meas + {8'h00, cal_adc_offset};

  // ****************************************************************
  // next register values
  // ****************************************************************
  // a write replaces the whole byte, reserved bits kept as written
  wire [7:0] next_cal_adc_offset =
    wr_offset ? i_req.wdata : cal_adc_offset;
  wire [7:0] next_pump_test_mode =
    wr_pump ? i_req.wdata : pump_test_mode;
  wire [7:0] next_adc_divider_lock_ctrl =
    wr_lockctl ? i_req.wdata : adc_divider_lock_ctrl;
  wire [7:0] next_signal_path_ctrl =
    wr_path ? i_req.wdata : signal_path_ctrl;

  // result holds until a fresh measurement arrives
  wire [15:0] next_osc_cal_result =
    i_cal_meas_valid ? cal_corrected : osc_cal_result;

  // read data holds between reads
  wire [7:0] next_rdata = i_req.rd ? rd_mux : o_rdata;

  // synchronised level moves only once flops two and three agree
  wire next_phase_ok =
    (phase_sync[1] == phase_sync[2]) ? phase_sync[2] : phase_ok;

  // ****************************************************************
  // decoded controls
  // ****************************************************************
  wire [1:0] pump_sel = pump_test_mode[PUMP_SEL_HI:PUMP_SEL_LO];
  path_ctrl_t next_ctrl;
  assign next_ctrl.pump_tristate        = (pump_sel == PUMP_TRISTATE);
  assign next_ctrl.pump_normal          = (pump_sel == PUMP_NORMAL);
  assign next_ctrl.adc_clk_run          =
    i_adc_enable | ~adc_divider_lock_ctrl[ADC_CLK_OFF_BIT];
  assign next_ctrl.feedback_divider_off =
    adc_divider_lock_ctrl[DIV_OFF_BIT];
  assign next_ctrl.rf_bias_off          =
    signal_path_ctrl[RF_BIAS_OFF_BIT];
  assign next_ctrl.if_amp_off           =
    signal_path_ctrl[IF_AMP_OFF_HI:IF_AMP_OFF_LO];
  assign next_ctrl.mixer_bypass_select  =
    ~signal_path_ctrl[MIXER_BYPASS_BIT];
  assign next_ctrl.if_switch_on         =
    signal_path_ctrl[IF_SWITCH_BIT];

  // ****************************************************************
  // writable registers, read-only ones take no write
  // ****************************************************************
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cal_adc_offset        <= RST_CAL_ADC_OFFSET;
      pump_test_mode        <= RST_PUMP_TEST_MODE;
      adc_divider_lock_ctrl <= RST_ADC_DIVIDER_LOCK_CTRL;
      signal_path_ctrl      <= RST_SIGNAL_PATH_CTRL;
    end else begin
      cal_adc_offset        <= next_cal_adc_offset;
      pump_test_mode        <= next_pump_test_mode;
      adc_divider_lock_ctrl <= next_adc_divider_lock_ctrl;
      signal_path_ctrl      <= next_signal_path_ctrl;
    end
  end

  // ****************************************************************
  // calibration result
  // ****************************************************************
  // capture, written by hardware only
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      osc_cal_result <= 16'h0000;
    end else begin
      osc_cal_result <= next_osc_cal_result;
    end
  end

  // ****************************************************************
  // read port
  // ****************************************************************
  // answer one cycle after the request
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rdata    <= 8'h00;
      o_rd_valid <= 1'b0;
    end else begin
      o_rdata    <= next_rdata;
      o_rd_valid <= i_req.rd;
    end
  end

  // ****************************************************************
  // registered outputs
  // ****************************************************************
  // decoded controls, one cycle behind the registers
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_ctrl <= '0;
    end else begin
      o_ctrl <= next_ctrl;
    end
  end

  // offset copy for the calibration path
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_cal_adc_offset <= 8'h00;
    end else begin
      o_cal_adc_offset <= cal_adc_offset;
    end
  end

  // lock state output, retimed once more; status readback uses lock_state directly
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_lock_state <= 1'b0;
    end else begin
      o_lock_state <= lock_state;
    end
  end

  // ****************************************************************
  // phase comparator pin synchroniser and lock detect
  // ****************************************************************
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      phase_sync <= 3'h0;
      phase_ok   <= 1'b0;
    end else begin
      phase_sync <= {phase_sync[1:0], i_phase_ok_pin};
      phase_ok   <= next_phase_ok;
    end
  end

  lock_detector u_lock (
    .i_clk              (i_clk),
    .i_arst_n           (i_arst_n),
    .i_cmp_tick         (i_cmp_tick),
    .i_phase_ok         (phase_ok),
    .i_lock_cycle_count (i_lock_cycle_count),
    .i_lock_count_scale (adc_divider_lock_ctrl[LOCK_SCALE_BIT]),
    .o_lock_state       (lock_state)
  );

endmodule : synth_and_path_ctrl_regs

// >>> verilog/synth_path_pkg.sv
package synth_path_pkg;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [11:0] OFS_CAL_ADC_OFFSET        = 12'h003a;
  localparam logic [11:0] OFS_PUMP_TEST_MODE        = 12'h003e;
  localparam logic [11:0] OFS_OSC_CAL_RESULT_LOW    = 12'h006e;
  localparam logic [11:0] OFS_OSC_CAL_RESULT_HIGH   = 12'h006f;
  localparam logic [11:0] OFS_ADC_DIVIDER_LOCK_CTRL = 12'h0073;
  localparam logic [11:0] OFS_LOCK_STATUS           = 12'h007c;
  localparam logic [11:0] OFS_SIGNAL_PATH_CTRL      = 12'h0100;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0] RST_CAL_ADC_OFFSET        = 8'h00;
  localparam logic [7:0] RST_PUMP_TEST_MODE        = 8'h00;
  localparam logic [7:0] RST_ADC_DIVIDER_LOCK_CTRL = 8'h00;
  localparam logic [7:0] RST_SIGNAL_PATH_CTRL      = 8'h03;
  localparam logic [7:0] RD_UNMAPPED               = 8'h00;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int PUMP_SEL_HI      = 3;
  localparam int PUMP_SEL_LO      = 2;
  localparam int ADC_CLK_OFF_BIT  = 2;
  localparam int DIV_OFF_BIT      = 1;
  localparam int LOCK_SCALE_BIT   = 0;
  localparam int LOCK_STATE_BIT   = 0;
  localparam int RF_BIAS_OFF_BIT  = 7;
  localparam int IF_AMP_OFF_HI    = 5;
  localparam int IF_AMP_OFF_LO    = 3;
  localparam int MIXER_BYPASS_BIT = 1;
  localparam int IF_SWITCH_BIT    = 0;

  // ****************************************************************
  // pump test codes and lock counts
  // ****************************************************************
  localparam logic [1:0] PUMP_TRISTATE = 2'h0;
  localparam logic [1:0] PUMP_NORMAL   = 2'h3;
  localparam logic [13:0] LOCK_BASE_COUNT = 14'h0400; // 1024 cycles
  localparam int          LOCK_SCALE_SHIFT = 5;       // divide by 32

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [11:0] addr;
    logic [7:0]  wdata;
  } reg_req_t;

  typedef struct packed {
    logic       pump_tristate;
    logic       pump_normal;
    logic       adc_clk_run;
    logic       feedback_divider_off;
    logic       rf_bias_off;
    logic [2:0] if_amp_off;
    logic       mixer_bypass_select;
    logic       if_switch_on;
  } path_ctrl_t;

endpackage : synth_path_pkg
